//--- include/button_split_pkg.sv
package button_split_pkg;

    // ==========================================================
    // Register indices; byte address is four times the index
    // ==========================================================
    localparam logic [9:0] IDX_AD_LEVEL   = 10'h0C8;
    localparam logic [9:0] IDX_DB_LEVEL   = 10'h0C9;
    localparam logic [9:0] IDX_BC_LEVEL   = 10'h0CA;
    localparam logic [9:0] IDX_CMIC_LEVEL = 10'h0CB;
    localparam logic [9:0] IDX_JACK_OVR   = 10'h0CC;
    localparam logic [9:0] IDX_DET_CTRL   = 10'h0D0;
    localparam logic [9:0] IDX_STATUS     = 10'h0D1;
    localparam logic [9:0] IDX_PRESS_CNT  = 10'h0D2;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RST_AD_LEVEL   = 8'h0A;
    localparam logic [7:0] RST_DB_LEVEL   = 8'h16;
    localparam logic [7:0] RST_BC_LEVEL   = 8'h21;
    localparam logic [7:0] RST_CMIC_LEVEL = 8'h3E;
    localparam logic [7:0] RST_JACK_OVR   = 8'h00;
    localparam logic [7:0] RST_DET_CTRL   = 8'h03;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int JACK_TYPE_FORCE_BIT = 5;
    localparam int PIN_ORDER_FORCE_BIT = 4;
    localparam int JACK_DET_EN_BIT     = 0;
    localparam int PIN_DET_EN_BIT      = 1;
    localparam int ST_CODE_LSB         = 0;
    localparam int ST_RESULT_LSB       = 8;
    localparam int ST_FOUR_POLE_BIT    = 13;
    localparam int ST_LRMG_BIT         = 14;
    localparam int ST_KEY_HELD_BIT     = 15;

    // One-hot result positions: A, D, B, C, microphone
    localparam int RES_A   = 0;
    localparam int RES_D   = 1;
    localparam int RES_B   = 2;
    localparam int RES_C   = 3;
    localparam int RES_MIC = 4;
    localparam int RES_W   = 5;
    localparam logic [RES_W-1:0] RST_RESULT = 5'h10;

    // Split level order inside the level array
    localparam int LVL_AD   = 0;
    localparam int LVL_DB   = 1;
    localparam int LVL_BC   = 2;
    localparam int LVL_CMIC = 3;
    localparam int LVL_N    = 4;

endpackage

//--- src/reset_sync.sv
module reset_sync
    import button_split_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    output logic      sync_resetn_o
);

    logic stage1_ff;
    logic stage2_ff;

    // Assert at once, release two edges later
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= 1'b1;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_resetn_o = stage2_ff;

endmodule

//--- src/split_level_classifier.sv
module split_level_classifier
    import button_split_pkg::*;
#(
    parameter int CODE_W = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic              code_valid_i,
    input  wire logic [CODE_W-1:0] level_ad_i,
    input  wire logic [CODE_W-1:0] level_db_i,
    input  wire logic [CODE_W-1:0] level_bc_i,
    input  wire logic [CODE_W-1:0] level_cmic_i,
    output logic [RES_W-1:0]       result_o,
    output logic [CODE_W-1:0]      code_o,
    output logic                   result_valid_o
);

    logic [RES_W-1:0]  result_ff;
    logic [CODE_W-1:0] code_ff;
    logic              valid_ff;
    logic              below_ad;
    logic              below_db;
    logic              below_bc;
    logic              below_cmic;
    logic [RES_W-1:0]  nxt_result;

    // Unsigned compares only
    assign below_ad   = code_i < level_ad_i;
    assign below_db   = code_i < level_db_i;
    assign below_bc   = code_i < level_bc_i;
    assign below_cmic = code_i < level_cmic_i;

    // Priority chain: AD level tested first, then DB, BC, CMIC; first hit wins
    // Misordered levels still yield one key, never two
    assign nxt_result[RES_A]   = below_ad;
    assign nxt_result[RES_D]   = !below_ad && below_db;
    assign nxt_result[RES_B]   = !below_ad && !below_db && below_bc;
    assign nxt_result[RES_C]   = !below_ad && !below_db && !below_bc && below_cmic;
    assign nxt_result[RES_MIC] = !below_ad && !below_db && !below_bc && !below_cmic;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_ff <= RST_RESULT;
            code_ff   <= '0;
            valid_ff  <= 1'b0;
        end else begin
            valid_ff <= code_valid_i;
            if (code_valid_i) begin
                result_ff <= nxt_result;
                code_ff   <= code_i;
            end
        end
    end

    assign result_o       = result_ff;
    assign code_o         = code_ff;
    assign result_valid_o = valid_ff;

endmodule

//--- src/headset_button_classifier.sv
module headset_button_classifier
    import button_split_pkg::*;
#(
    parameter int CODE_W = 8,
    parameter int CNT_W  = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Measurement path
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic              code_valid_i,
    // Automatic detection results
    input  wire logic              det_four_pole_i,
    input  wire logic              det_lrmg_i,
    // Decision outputs
    output logic [RES_W-1:0]       result_o,
    output logic                   result_valid_o,
    output logic                   press_o,
    output logic                   release_o,
    output logic                   four_pole_o,
    output logic                   lrmg_o
);

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rstn;

    reset_sync u_reset_sync (
        .mclk_i        (mclk_i),
        .resetn_i      (resetn_i),
        .sync_resetn_o (rstn)
    );

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic idx_hit(input logic [11:0] addr, input logic [9:0] idx);
        idx_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    logic       setup_phase;
    logic       wr_access;
    logic       lane0_wr;
    logic       hit_ad;
    logic       hit_db;
    logic       hit_bc;
    logic       hit_cmic;
    logic       hit_jack;
    logic       hit_ctrl;
    logic       hit_status;
    logic       hit_cnt;
    logic       hit_any;
    logic [LVL_N-1:0] hit_level;

    assign setup_phase = psel_i && !penable_i;
    assign wr_access   = psel_i && penable_i && pwrite_i;
    assign lane0_wr    = wr_access && pstrb_i[0];
    assign hit_ad      = idx_hit(paddr_i, IDX_AD_LEVEL);
    assign hit_db      = idx_hit(paddr_i, IDX_DB_LEVEL);
    assign hit_bc      = idx_hit(paddr_i, IDX_BC_LEVEL);
    assign hit_cmic    = idx_hit(paddr_i, IDX_CMIC_LEVEL);
    assign hit_jack    = idx_hit(paddr_i, IDX_JACK_OVR);
    assign hit_ctrl    = idx_hit(paddr_i, IDX_DET_CTRL);
    assign hit_status  = idx_hit(paddr_i, IDX_STATUS);
    assign hit_cnt     = idx_hit(paddr_i, IDX_PRESS_CNT);
    assign hit_level   = {hit_cmic, hit_bc, hit_db, hit_ad};
    assign hit_any     = |hit_level || hit_jack || hit_ctrl || hit_status || hit_cnt;

    // Zero wait states: every access completes in its first access cycle
    assign pready_o  = 1'b1;
    // Read-only registers refuse writes as well
    assign pslverr_o = psel_i && penable_i && (!hit_any || (pwrite_i && (hit_status || hit_cnt)));

    // ==========================================================
    // Split level registers
    // ==========================================================
    localparam logic [7:0] LEVEL_RST [LVL_N] = '{RST_AD_LEVEL, RST_DB_LEVEL,
                                                 RST_BC_LEVEL, RST_CMIC_LEVEL};

    logic [7:0] level_ff [LVL_N];

    // Levels are taken as written; scaling against the bias divider is software's job
    generate
        for (genvar g = 0; g < LVL_N; g++) begin : g_level
            always_ff @(posedge mclk_i or negedge rstn) begin
                if (!rstn) begin
                    level_ff[g] <= LEVEL_RST[g];
                end else if (lane0_wr && hit_level[g]) begin
                    level_ff[g] <= pwdata_i[7:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Jack override and detection control
    // ==========================================================
    logic [7:0] jack_ovr_ff;
    logic [1:0] det_ctrl_ff;

    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            jack_ovr_ff <= RST_JACK_OVR;
            det_ctrl_ff <= RST_DET_CTRL[1:0];
        end else begin
            if (lane0_wr && hit_jack) begin
                jack_ovr_ff <= pwdata_i[7:0];
            end
            if (lane0_wr && hit_ctrl) begin
                det_ctrl_ff <= pwdata_i[1:0];
            end
        end
    end

    logic jack_det_en;
    logic pin_det_en;
    logic nxt_four_pole;
    logic nxt_lrmg;

    assign jack_det_en   = det_ctrl_ff[JACK_DET_EN_BIT];
    assign pin_det_en    = det_ctrl_ff[PIN_DET_EN_BIT];
    assign nxt_four_pole = jack_det_en ? det_four_pole_i
                                       : jack_ovr_ff[JACK_TYPE_FORCE_BIT];
    assign nxt_lrmg      = pin_det_en ? det_lrmg_i
                                      : jack_ovr_ff[PIN_ORDER_FORCE_BIT];

    logic four_pole_ff;
    logic lrmg_ff;

    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            four_pole_ff <= 1'b0;
            lrmg_ff      <= 1'b0;
        end else begin
            four_pole_ff <= nxt_four_pole;
            lrmg_ff      <= nxt_lrmg;
        end
    end

    assign four_pole_o = four_pole_ff;
    assign lrmg_o      = lrmg_ff;

    // ==========================================================
    // Classification
    // ==========================================================
    logic [RES_W-1:0]  result;
    logic [CODE_W-1:0] last_code;
    logic              result_valid;

    split_level_classifier #(
        .CODE_W (CODE_W)
    ) u_classifier (
        .mclk_i         (mclk_i),
        .rstn_i         (rstn),
        .code_i         (code_i),
        .code_valid_i   (code_valid_i),
        .level_ad_i     (level_ff[LVL_AD][CODE_W-1:0]),
        .level_db_i     (level_ff[LVL_DB][CODE_W-1:0]),
        .level_bc_i     (level_ff[LVL_BC][CODE_W-1:0]),
        .level_cmic_i   (level_ff[LVL_CMIC][CODE_W-1:0]),
        .result_o       (result),
        .code_o         (last_code),
        .result_valid_o (result_valid)
    );

    assign result_o       = result;
    assign result_valid_o = result_valid;

    // ==========================================================
    // Press and release events
    // ==========================================================
    logic             key_held_ff;
    logic [RES_W-1:0] held_key_ff;
    logic             press_ff;
    logic             release_ff;
    logic [CNT_W-1:0] press_cnt_ff;
    logic             new_is_key;
    logic             key_changed;
    logic             nxt_press;
    logic             nxt_release;

    // A switch from one key to another counts as release plus press
    assign new_is_key  = !result[RES_MIC];
    assign key_changed = key_held_ff && new_is_key && (result != held_key_ff);
    assign nxt_press   = result_valid && new_is_key && (!key_held_ff || key_changed);
    assign nxt_release = result_valid && key_held_ff && (!new_is_key || key_changed);

    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            key_held_ff  <= 1'b0;
            held_key_ff  <= RST_RESULT;
            press_ff     <= 1'b0;
            release_ff   <= 1'b0;
            press_cnt_ff <= '0;
        end else begin
            press_ff   <= nxt_press;
            release_ff <= nxt_release;
            if (result_valid) begin
                key_held_ff <= new_is_key;
                held_key_ff <= result;
            end
            // Counter wraps; software reads differences
            if (nxt_press) begin
                press_cnt_ff <= press_cnt_ff + CNT_W'(1);
            end
        end
    end

    assign press_o   = press_ff;
    assign release_o = release_ff;

    // ==========================================================
    // Read data, captured in the setup cycle
    // ==========================================================
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    logic [31:0] prdata_ff;

    always_comb begin
        status_word = '0;
        status_word[ST_CODE_LSB +: CODE_W]  = last_code;
        status_word[ST_RESULT_LSB +: RES_W] = result;
        status_word[ST_FOUR_POLE_BIT]       = four_pole_ff;
        status_word[ST_LRMG_BIT]            = lrmg_ff;
        status_word[ST_KEY_HELD_BIT]        = key_held_ff;
    end

    assign rd_mux = hit_ad     ? {24'h000000, level_ff[LVL_AD]}   :
                    hit_db     ? {24'h000000, level_ff[LVL_DB]}   :
                    hit_bc     ? {24'h000000, level_ff[LVL_BC]}   :
                    hit_cmic   ? {24'h000000, level_ff[LVL_CMIC]} :
                    hit_jack   ? {24'h000000, jack_ovr_ff}        :
                    hit_ctrl   ? {30'h00000000, det_ctrl_ff}      :
                    hit_status ? status_word                      :
                    hit_cnt    ? 32'(press_cnt_ff)                :
                                 32'h00000000;

    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            prdata_ff <= 32'h00000000;
        end else if (setup_phase && !pwrite_i) begin
            prdata_ff <= rd_mux;
        end
    end

    assign prdata_o = prdata_ff;

endmodule

//--- tb/headset_accessory_model.sv
module headset_accessory_model (
    input  wire logic mclk_i,
    output logic [7:0] code_o,
    output logic       code_valid_o,
    output logic       four_pole_o,
    output logic       lrmg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        code_o = 8'h00;
        code_valid_o = 1'b0;
        four_pole_o = 1'b0;
        lrmg_o = 1'b0;
    end
    // Code line shows inverse once invalid, so stale data cannot pass
    task automatic measure(input logic [7:0] c);
        @(posedge mclk_i);
        code_o <= c;
        code_valid_o <= 1'b1;
        @(posedge mclk_i);
        code_o <= ~c;
        code_valid_o <= 1'b0;
    endtask
    task automatic set_jack(input logic f, input logic l);
        @(posedge mclk_i);
        four_pole_o <= f;
        lrmg_o <= l;
    endtask
endmodule

//--- tb/button_split_props.sv
module button_split_props
    import button_split_pkg::*;
#(
    parameter int CODE_W = 8
) (
    input wire logic              mclk_i,
    input wire logic              resetn_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [11:0]       paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic              pready_o,
    input wire logic [CODE_W-1:0] code_i,
    input wire logic              code_valid_i,
    input wire logic              det_four_pole_i,
    input wire logic              det_lrmg_i,
    input wire logic [RES_W-1:0]  result_o,
    input wire logic              result_valid_o,
    input wire logic              four_pole_o,
    input wire logic              lrmg_o
);
    // ==========================================================
    // Shadow of the level and override registers
    // ==========================================================
    logic [7:0] lv_ff [LVL_N];
    logic [7:0] jo_ff;
    logic [1:0] dc_ff;
    wire        wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0] & pready_o & (paddr_i[1:0] == 2'h0);
    wire  [9:0] widx  = paddr_i[11:2];
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lv_ff <= '{RST_AD_LEVEL, RST_DB_LEVEL, RST_BC_LEVEL, RST_CMIC_LEVEL};
            jo_ff <= RST_JACK_OVR;
            dc_ff <= RST_DET_CTRL[1:0];
        end else if (wr_en) begin
            if (widx == IDX_AD_LEVEL) lv_ff[LVL_AD] <= pwdata_i[7:0];
            if (widx == IDX_DB_LEVEL) lv_ff[LVL_DB] <= pwdata_i[7:0];
            if (widx == IDX_BC_LEVEL) lv_ff[LVL_BC] <= pwdata_i[7:0];
            if (widx == IDX_CMIC_LEVEL) lv_ff[LVL_CMIC] <= pwdata_i[7:0];
            if (widx == IDX_JACK_OVR) jo_ff <= pwdata_i[7:0];
            if (widx == IDX_DET_CTRL) dc_ff <= pwdata_i[1:0];
        end
    end
    // The design leaves reset two edges after the pin, and $past needs one settled cycle on top
    logic [3:0] rs_ff;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rs_ff <= 4'h0;
        end else begin
            rs_ff <= {rs_ff[2:0], 1'b1};
        end
    end
    wire lo_ad = code_i < lv_ff[LVL_AD];
    wire lo_db = code_i < lv_ff[LVL_DB];
    wire lo_bc = code_i < lv_ff[LVL_BC];
    wire lo_cm = code_i < lv_ff[LVL_CMIC];
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rs_ff[3]);
    a_key_a: assert property (code_valid_i && lo_ad |=> result_o == 5'h01)
        else $error("key A not reported");
    a_key_d: assert property (code_valid_i && !lo_ad && lo_db |=> result_o == 5'h02)
        else $error("key D not reported");
    a_key_b: assert property (code_valid_i && !lo_ad && !lo_db && lo_bc |=> result_o == 5'h04)
        else $error("key B not reported");
    a_key_c: assert property (code_valid_i && !lo_ad && !lo_db && !lo_bc && lo_cm |=> result_o == 5'h08)
        else $error("key C not reported");
    a_mic_load: assert property (code_valid_i && !(lo_ad || lo_db || lo_bc || lo_cm) |=> result_o == 5'h10)
        else $error("microphone load misreported");
    a_one_hot: assert property (result_valid_o == $past(code_valid_i) && $onehot(result_o))
        else $error("result not a single one-hot pulse");
    a_jack_type: assert property (four_pole_o == ($past(dc_ff[0]) ? $past(det_four_pole_i) : $past(jo_ff[5])))
        else $error("jack type wrong");
    a_pin_order: assert property (lrmg_o == ($past(dc_ff[1]) ? $past(det_lrmg_i) : $past(jo_ff[4])))
        else $error("pin order wrong");
endmodule
bind headset_button_classifier button_split_props #(.CODE_W(CODE_W)) u_props (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .pready_o(pready_o), .code_i(code_i), .code_valid_i(code_valid_i),
    .det_four_pole_i(det_four_pole_i), .det_lrmg_i(det_lrmg_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .four_pole_o(four_pole_o), .lrmg_o(lrmg_o));

//--- tb/tb_headset_button_classifier.sv
module tb_headset_button_classifier
    import button_split_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIAS_OHM = 2200;
    localparam logic [7:0] R_CODE [14] = '{8'h00, 8'h09, 8'h0A, 8'h15, 8'h16, 8'h20, 8'h21, 8'h3D, 8'h3E, 8'hFF,
                                           8'h2E, 8'h2F, 8'h4F, 8'h50};
    localparam logic [4:0] R_RES [14] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h04, 5'h08, 5'h08, 5'h10, 5'h10,
                                          5'h04, 5'h08, 5'h08, 5'h10};
    localparam logic [9:0] R_IDX [6] = '{IDX_AD_LEVEL, IDX_DB_LEVEL, IDX_BC_LEVEL, IDX_CMIC_LEVEL, IDX_JACK_OVR,
                                         IDX_DET_CTRL};
    localparam logic [7:0] R_RST [6] = '{8'h0A, 8'h16, 8'h21, 8'h3E, 8'h00, 8'h03};
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [7:0]  code;
    logic        code_valid;
    logic        det_four;
    logic        det_lrmg;
    logic [4:0]  result_o;
    logic        result_valid_o;
    logic        four_pole_o;
    logic        lrmg_o;
    logic [31:0] rd;
    logic        er;
    logic        key_press;
    logic        key_release;
    int          n_press = 0;
    int          n_release = 0;
    int          n_mismatch = 0;
    int          n_compared = 0;
    always #5 mclk_i = ~mclk_i;
    // Pulses counted mid-cycle, away from the edge that launches them
    always @(negedge mclk_i) begin
        if (key_press === 1'b1) n_press++;
        if (key_release === 1'b1) n_release++;
    end
    headset_accessory_model u_headset_accessory_model (.mclk_i(mclk_i), .code_o(code), .code_valid_o(code_valid),
        .four_pole_o(det_four), .lrmg_o(det_lrmg));
    headset_button_classifier u_headset_button_classifier (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .code_i(code), .code_valid_i(code_valid),
        .det_four_pole_i(det_four), .det_lrmg_i(det_lrmg), .result_o(result_o), .result_valid_o(result_valid_o),
        .press_o(key_press), .release_o(key_release), .four_pole_o(four_pole_o), .lrmg_o(lrmg_o));
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic classify(input logic [7:0] c, input logic [4:0] exp);
        u_headset_accessory_model.measure(c);
        #1;
        chk(32'(result_valid_o), 32'h1);
        chk(32'(result_o), 32'(exp));
    endtask
    // Rounded so the level matches the worked figures of the bias divider
    function automatic logic [7:0] lvl(input int r);
        lvl = 8'((256 * r + (r + BIAS_OHM) / 2) / (r + BIAS_OHM));
    endfunction
    task automatic end_sim;
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        end_sim();
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, R_IDX[i], 32'h0);
            chk(rd, 32'(R_RST[i]));
        end
        for (int i = 0; i < 14; i++) begin
            if (i == 10) begin
                apb(1'b1, IDX_BC_LEVEL, 32'(lvl(500)));
                apb(1'b1, IDX_CMIC_LEVEL, 32'(lvl(1000)));
                apb(1'b0, IDX_BC_LEVEL, 32'h0);
                chk(rd, 32'h2F);
            end
            classify(R_CODE[i], R_RES[i]);
        end
        apb(1'b1, IDX_AD_LEVEL, 32'h40);
        apb(1'b1, IDX_CMIC_LEVEL, 32'hFF);
        // Lane 0 strobe low: write must be ignored
        pstrb <= 4'h0;
        apb(1'b1, IDX_AD_LEVEL, 32'h11);
        pstrb <= 4'hF;
        apb(1'b0, IDX_AD_LEVEL, 32'h0);
        chk(rd, 32'h40);
        classify(8'h30, 5'h01);
        classify(8'h80, 5'h08);
        apb(1'b1, IDX_DET_CTRL, 32'h0);
        u_headset_accessory_model.set_jack(1'b1, 1'b1);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, IDX_JACK_OVR, 32'(j) << 4);
            repeat (2) @(posedge mclk_i);
            chk(32'(four_pole_o), 32'(j >> 1));
            chk(32'(lrmg_o), 32'(j & 1));
        end
        apb(1'b1, IDX_DET_CTRL, 32'h3);
        repeat (2) @(posedge mclk_i);
        chk(32'({four_pole_o, lrmg_o}), 32'h3);
        // Key sequence so far: 8 presses, 7 releases, key C held
        chk(32'(n_press), 32'h8);
        chk(32'(n_release), 32'h7);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rd, 32'h0000E880);
        apb(1'b0, IDX_PRESS_CNT, 32'h0);
        chk(rd, 32'h8);
        apb(1'b1, IDX_PRESS_CNT, 32'hFF);
        chk(32'(er), 32'h1);
        apb(1'b0, IDX_PRESS_CNT, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, 10'h3FF, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        // Reset in mid-run: state must return to its defaults
        resetn_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk(32'(result_o), 32'h10);
        chk(32'({four_pole_o, lrmg_o}), 32'h0);
        @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        apb(1'b0, IDX_AD_LEVEL, 32'h0);
        chk(rd, 32'h0A);
        apb(1'b0, IDX_PRESS_CNT, 32'h0);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule
